/* core/ohp_pkg.sv */
// ohp_pkg: constants, types and register layout of the octal uart host bus port
// assumes: consumed by ohp_host_port and ohp_chan_pins, nothing imported
package ohp_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CH_SEL_W = 3;
  localparam int PANEL_W = 2;

  // ==========================================================================
  // address fields
  localparam int CH_SEL_LO = 3;
  localparam int REG_SEL_LO = 0;
  localparam int PANEL_LO = 6;

  // ==========================================================================
  // per-channel register indices inside the selected channel
  localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
  localparam logic [2:0] REG_AUTO_TOGGLE = 3'h5;
  localparam logic [2:0] REG_EXTRA_FEAT = 3'h6;

  // option register offsets on the low six address lines
  localparam logic [5:0] OPT_IRQ_MASK = 6'h00;
  localparam logic [5:0] OPT_IRQ_POLL = 6'h01;

  // ==========================================================================
  // field positions
  localparam int MODEM_IRQ_EN_BIT = 3;
  localparam int FEAT_IRQ_OFF_BIT = 4;
  localparam int FEAT_IRQ_POL_BIT = 5;
  localparam int TOGGLE_MODE_LO = 0;
  localparam int TOGGLE_TX_AUTO_BIT = 4;
  localparam int TOGGLE_TX_LVL_BIT = 5;
  localparam int TOGGLE_RX_AUTO_BIT = 6;
  localparam int TOGGLE_RX_LVL_BIT = 7;

  // pin modes held in auto_toggle_ctrl[1:0]
  localparam logic [1:0] PIN_MODE_READY = 2'h0;
  localparam logic [1:0] PIN_MODE_ENABLE = 2'h3;

  // ==========================================================================
  // reset values and the unmapped read value
  localparam logic [7:0] MODEM_CTRL_RESET = 8'h00;
  localparam logic [7:0] AUTO_TOGGLE_RESET = 8'h00;
  localparam logic [7:0] EXTRA_FEAT_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================================
  // sampled host pins travel together through the synchroniser
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic read_strobe_n;
    logic write_strobe_n;
    logic channel_select_n;
    logic option_select_n;
    logic multi_panel_mode;
    logic [1:0] panel_id;
  } ohp_pins_s;

  localparam ohp_pins_s PINS_IDLE = '{8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0};

  // host access sequencer
  typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} ohp_acc_e;

endpackage

/* core/ohp_chan_pins.sv */
// ohp_chan_pins: ready / enable pin pair of one uart channel
// assumes: status inputs come from the channel core on the same clock
`timescale 1ns/1ps
`default_nettype none
module ohp_chan_pins (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] auto_toggle_ctrl,
  input wire logic tx_fifo_ready,
  input wire logic rx_fifo_ready,
  input wire logic tx_busy,
  output logic tx_pin_q,
  output logic rx_pin_q
);

  // ==========================================================================
  // field decode
  logic [1:0] mode;
  logic tx_auto, tx_lvl, rx_auto, rx_lvl;
  logic tx_pin_d, rx_pin_d;
  assign mode = auto_toggle_ctrl[ohp_pkg::TOGGLE_MODE_LO +: 2];
  assign tx_auto = auto_toggle_ctrl[ohp_pkg::TOGGLE_TX_AUTO_BIT];
  assign tx_lvl = auto_toggle_ctrl[ohp_pkg::TOGGLE_TX_LVL_BIT];
  assign rx_auto = auto_toggle_ctrl[ohp_pkg::TOGGLE_RX_AUTO_BIT];
  assign rx_lvl = auto_toggle_ctrl[ohp_pkg::TOGGLE_RX_LVL_BIT];

  // ==========================================================================
  // next pin values; the unused codes 01/10 keep ready behaviour so the pin
  // never floats into an undefined meaning
  always_comb begin
    if (mode == ohp_pkg::PIN_MODE_ENABLE) begin
      // auto-toggle: drive level while sending, its inverse once done
      tx_pin_d = tx_auto ? (tx_busy ? tx_lvl : ~tx_lvl) : tx_lvl; // see R14, R19, R12
      // with rx auto-toggle the receiver is opened only while our own transmitter is quiet
      rx_pin_d = rx_auto ? (tx_busy ? ~rx_lvl : rx_lvl) : rx_lvl; // see R17, R15
    end else begin
      tx_pin_d = ~tx_fifo_ready; // see R13, R12
      rx_pin_d = ~rx_fifo_ready; // see R16, R15
    end
  end

  // registered so the pins never glitch on status changes
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_pin_q <= 1'b1;
      rx_pin_q <= 1'b1;
    end else begin
      tx_pin_q <= tx_pin_d;
      rx_pin_q <= rx_pin_d;
    end
  end

  // ==========================================================================
  // checks
  tx_static_level_a: assert property (@(posedge clk) disable iff (reset) // see R14
    (mode == ohp_pkg::PIN_MODE_ENABLE && !tx_auto) |=> (tx_pin_q == $past(tx_lvl)))
    else $error("tx enable not at static level");
  rx_ready_follow_a: assert property (@(posedge clk) disable iff (reset) // see R16
    (mode == ohp_pkg::PIN_MODE_READY) |=> (rx_pin_q == !$past(rx_fifo_ready)))
    else $error("rx ready pin does not follow buffer state");
  tx_auto_done_a: assert property (@(posedge clk) disable iff (reset) // see R19
    (mode == ohp_pkg::PIN_MODE_ENABLE && tx_auto && $fell(tx_busy)) |=> (tx_pin_q != tx_lvl))
    else $error("tx enable still asserted after transmission");
  tx_auto_cov: cover property (@(posedge clk) disable iff (reset)
    mode == ohp_pkg::PIN_MODE_ENABLE && tx_auto && tx_busy ##1 !tx_busy);

endmodule
`default_nettype wire

/* core/ohp_host_port.sv */
// ohp_host_port: parallel host port of an eight channel uart
// holds address decode, strobes, option registers, global interrupt merge
// and the per-channel ready / enable pins.
// assumes: host pins are asynchronous and sampled through two flops; the
// channel status inputs come from the uart cores on clk.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: normal mode ignores two top address lines
// R2: a[5:3] pick channel, a[2:0] register
// R3: multi-panel mode matches a[7:6] to panel
// R4: selected read drives addressed register out
// R5: selected write stores bus data in register
// R6: channel select gates uart register transfers
// R7: option select reaches option registers, multi-panel
// R8: transceiver enable low while driving, multi-panel
// R9: channel irq counts if modem bit3, feature bit4 clear
// R10: extra-feature bit 5 sets irq polarity
// R11: poll register shows irqs, mask gates them
// R12: tx pin ready at 00, enable at 11
// R13: tx ready follows transmit buffer state
// R14: tx enable static or auto-toggle, level bit5
// R15: rx pin ready at 00, enable at 11
// R16: rx ready follows receive buffer state
// R17: rx enable static or auto-toggle, level bit7
// R18: data bus released unless returning read data
// R19: auto-toggle asserts while sending, drops after
// R20: unselected strobes change nothing at all
module ohp_host_port #(
  parameter int NUM_CH = ohp_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic channel_select_n,
  input wire logic option_select_n,
  input wire logic multi_panel_mode,
  input wire logic [1:0] panel_id,
  output logic transceiver_enable_n,
  output logic global_irq,
  input wire logic [NUM_CH-1:0] channel_irq,
  input wire logic [NUM_CH-1:0] tx_fifo_ready,
  input wire logic [NUM_CH-1:0] rx_fifo_ready,
  input wire logic [NUM_CH-1:0] tx_busy,
  output logic [NUM_CH-1:0] tx_ready_n,
  output logic [NUM_CH-1:0] rx_ready_n
);

  // ==========================================================================
  // elaboration check: the decode carries exactly eight channels
  if (NUM_CH != ohp_pkg::NUM_CH) begin : g_bad_num_ch
    $error("ohp_host_port serves exactly eight channels");
  end

  // ==========================================================================
  // pin synchroniser; stage one is read only by stage two
  ohp_pkg::ohp_pins_s pins_raw;
  ohp_pkg::ohp_pins_s pins_meta_q;
  ohp_pkg::ohp_pins_s pins_q;

  assign pins_raw = '{addr, data_in, read_strobe_n, write_strobe_n,
                      channel_select_n, option_select_n, multi_panel_mode, panel_id};

  always_ff @(posedge clk) begin
    if (reset) begin
      pins_meta_q <= ohp_pkg::PINS_IDLE;
      pins_q <= ohp_pkg::PINS_IDLE;
    end else begin
      pins_meta_q <= pins_raw;
      pins_q <= pins_meta_q;
    end
  end

  // ==========================================================================
  // address decode on the synchronised pins
  logic panel_hit;
  logic uart_sel;
  logic opt_sel;
  logic any_sel;
  logic [ohp_pkg::CH_SEL_W-1:0] chan;
  logic [2:0] reg_idx;
  logic [5:0] low_addr;

  // normal mode never looks at the top two lines
  assign panel_hit = !pins_q.multi_panel_mode || // see R1
    (pins_q.addr[ohp_pkg::PANEL_LO +: ohp_pkg::PANEL_W] == pins_q.panel_id); // see R3
  assign chan = pins_q.addr[ohp_pkg::CH_SEL_LO +: ohp_pkg::CH_SEL_W]; // see R2
  assign reg_idx = pins_q.addr[ohp_pkg::REG_SEL_LO +: 3]; // see R2
  assign low_addr = pins_q.addr[5:0];
  // channel select wins if a host asserts both selects together
  assign uart_sel = !pins_q.channel_select_n && panel_hit; // see R6
  assign opt_sel = pins_q.multi_panel_mode && !pins_q.option_select_n && panel_hit
                   && pins_q.channel_select_n; // see R7
  assign any_sel = uart_sel || opt_sel; // see R20

  // ==========================================================================
  // register storage: per-channel flip-flops indexed by channel, one mask register, a wired poll value
  logic [7:0] modem_control_reg_q [NUM_CH];
  logic [7:0] auto_toggle_ctrl_q [NUM_CH];
  logic [7:0] extra_feature_reg_q [NUM_CH];
  logic [7:0] irq_mask_reg_q;
  logic [NUM_CH-1:0] irq_poll_reg;

  // ==========================================================================
  // access sequencer: a strobe edge starts an access, its release ends it
  ohp_pkg::ohp_acc_e acc_q;
  logic acc_opt_q;
  logic [2:0] acc_chan_q;
  logic [5:0] acc_addr_q;
  logic [7:0] wdata_q;
  logic commit;

  // write commits on the trailing edge of the strobe, when data is settled
  assign commit = (acc_q == ohp_pkg::ACC_WRITE) && pins_q.write_strobe_n;

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_q <= ohp_pkg::ACC_IDLE;
    end else begin
      unique case (acc_q)
        ohp_pkg::ACC_IDLE: begin
          if (any_sel && !pins_q.read_strobe_n) begin
            acc_q <= ohp_pkg::ACC_READ; // see R4
          end else if (any_sel && !pins_q.write_strobe_n) begin
            acc_q <= ohp_pkg::ACC_WRITE; // see R5
          end
        end
        ohp_pkg::ACC_READ: begin
          // dropping the select also ends the read, so the bus is freed
          if (pins_q.read_strobe_n || !any_sel) begin
            acc_q <= ohp_pkg::ACC_IDLE;
          end
        end
        ohp_pkg::ACC_WRITE: begin
          if (pins_q.write_strobe_n) begin
            acc_q <= ohp_pkg::ACC_IDLE;
          end
        end
      endcase
    end
  end

  // target of the access is frozen at its start
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_opt_q <= 1'b0;
      acc_chan_q <= 3'h0;
      acc_addr_q <= 6'h00;
    end else if (acc_q == ohp_pkg::ACC_IDLE && any_sel) begin
      acc_opt_q <= opt_sel;
      acc_chan_q <= chan;
      acc_addr_q <= low_addr;
    end
  end

  // data is sampled every cycle the strobe is low while selected or in a write; the last sample is kept
  always_ff @(posedge clk) begin
    if (reset) begin
      wdata_q <= 8'h00;
    end else if (!pins_q.write_strobe_n && (acc_q == ohp_pkg::ACC_WRITE || any_sel)) begin
      wdata_q <= pins_q.data; // see R5
    end
  end

  // ==========================================================================
  // channel registers written by the host
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        modem_control_reg_q[i] <= ohp_pkg::MODEM_CTRL_RESET;
        auto_toggle_ctrl_q[i] <= ohp_pkg::AUTO_TOGGLE_RESET;
        extra_feature_reg_q[i] <= ohp_pkg::EXTRA_FEAT_RESET;
      end
    end else if (commit && !acc_opt_q) begin
      unique case (acc_addr_q[2:0])
        ohp_pkg::REG_MODEM_CTRL: modem_control_reg_q[acc_chan_q] <= wdata_q; // see R5
        ohp_pkg::REG_AUTO_TOGGLE: auto_toggle_ctrl_q[acc_chan_q] <= wdata_q;
        ohp_pkg::REG_EXTRA_FEAT: extra_feature_reg_q[acc_chan_q] <= wdata_q;
        default: ; // other channel registers live in the uart core
      endcase
    end
  end

  // option mask register; the poll register is read only
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_mask_reg_q <= ohp_pkg::IRQ_MASK_RESET;
    end else if (commit && acc_opt_q && acc_addr_q == ohp_pkg::OPT_IRQ_MASK) begin
      irq_mask_reg_q <= wdata_q; // see R7, R11
    end
  end

  // ==========================================================================
  // read mux, evaluated on the live decode at the start of a read
  logic [7:0] rd_val;

  always_comb begin
    rd_val = ohp_pkg::UNMAPPED_READ;
    if (opt_sel) begin
      if (low_addr == ohp_pkg::OPT_IRQ_MASK) begin
        rd_val = irq_mask_reg_q;
      end else if (low_addr == ohp_pkg::OPT_IRQ_POLL) begin
        rd_val = irq_poll_reg; // see R11
      end
    end else begin
      unique case (reg_idx)
        ohp_pkg::REG_MODEM_CTRL: rd_val = modem_control_reg_q[chan];
        ohp_pkg::REG_AUTO_TOGGLE: rd_val = auto_toggle_ctrl_q[chan];
        ohp_pkg::REG_EXTRA_FEAT: rd_val = extra_feature_reg_q[chan];
        default: rd_val = ohp_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // data bus driver: value captured once, enable held through the read
  logic start_read;
  assign start_read = (acc_q == ohp_pkg::ACC_IDLE) && any_sel && !pins_q.read_strobe_n;

  always_ff @(posedge clk) begin
    if (reset) begin
      data_out <= 8'h00;
    end else if (start_read) begin
      data_out <= rd_val; // see R4
    end
  end

  // enable drops the cycle the read ends, so the bus is released promptly
  always_ff @(posedge clk) begin
    if (reset) begin
      data_oe <= 1'b0;
      transceiver_enable_n <= 1'b1;
    end else begin
      data_oe <= start_read ||
                 (acc_q == ohp_pkg::ACC_READ && !pins_q.read_strobe_n && any_sel); // see R18
      transceiver_enable_n <= !(pins_q.multi_panel_mode && (start_read ||
                 (acc_q == ohp_pkg::ACC_READ && !pins_q.read_strobe_n && any_sel))); // see R8
    end
  end

  // ==========================================================================
  // interrupt merge
  logic [NUM_CH-1:0] irq_enabled;
  logic irq_any;
  logic irq_pol;

  // the polarity is taken from channel zero's extra-feature register
  assign irq_pol = extra_feature_reg_q[0][ohp_pkg::FEAT_IRQ_POL_BIT];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_irq
    assign irq_enabled[c] = channel_irq[c] &&
      modem_control_reg_q[c][ohp_pkg::MODEM_IRQ_EN_BIT] &&
      !extra_feature_reg_q[c][ohp_pkg::FEAT_IRQ_OFF_BIT]; // see R9
    // every channel is watched, so a wrong index in the merge is caught
    irq_gate_a: assert property (@(posedge clk) disable iff (reset) // see R9
      (channel_irq[c] && !modem_control_reg_q[c][ohp_pkg::MODEM_IRQ_EN_BIT])
      |-> !irq_enabled[c])
      else $error("disabled channel interrupt reached merge");
  end

  // poll shows raw channel state; a mask bit set blocks that channel
  assign irq_poll_reg = channel_irq; // see R11
  assign irq_any = |(irq_enabled & ~irq_mask_reg_q); // see R11, R9

  // inactive level right out of reset is high, as polarity bit is zero;
  // a host that never touches polarity sees an active-low line
  always_ff @(posedge clk) begin
    if (reset) begin
      global_irq <= 1'b1;
    end else begin
      global_irq <= irq_pol ? irq_any : !irq_any; // see R10
    end
  end

  // ==========================================================================
  // per-channel ready / enable pins
  for (genvar c = 0; c < NUM_CH; c++) begin : g_pins
    ohp_chan_pins u_pins (
      .clk(clk),
      .reset(reset),
      .auto_toggle_ctrl(auto_toggle_ctrl_q[c]),
      .tx_fifo_ready(tx_fifo_ready[c]),
      .rx_fifo_ready(rx_fifo_ready[c]),
      .tx_busy(tx_busy[c]),
      .tx_pin_q(tx_ready_n[c]),
      .rx_pin_q(rx_ready_n[c])
    );
  end

  // ==========================================================================
  // checks; they watch the synchronised pins, two clocks behind the pads
  normal_top_ignored_a: assert property (@(posedge clk) disable iff (reset) // see R1
    (!pins_q.multi_panel_mode && !pins_q.channel_select_n) |-> uart_sel)
    else $error("normal mode access refused by top address lines");

  panel_mismatch_a: assert property (@(posedge clk) disable iff (reset) // see R3
    (pins_q.multi_panel_mode && pins_q.addr[7:6] != pins_q.panel_id) |-> !any_sel)
    else $error("foreign panel access accepted");

  read_drive_a: assert property (@(posedge clk) disable iff (reset) // see R4
    start_read |=> (data_oe && data_out == $past(rd_val)))
    else $error("read did not drive addressed register");

  write_store_a: assert property (@(posedge clk) disable iff (reset) // see R5
    (commit && acc_opt_q && acc_addr_q == ohp_pkg::OPT_IRQ_MASK)
    |=> (irq_mask_reg_q == $past(wdata_q)))
    else $error("mask register write lost");

  opt_normal_block_a: assert property (@(posedge clk) disable iff (reset) // see R7
    !pins_q.multi_panel_mode |-> !opt_sel)
    else $error("option select active in normal mode");

  buf_tracks_oe_a: assert property (@(posedge clk) disable iff (reset) // see R8
    (transceiver_enable_n == !(data_oe && $past(pins_q.multi_panel_mode))))
    else $error("transceiver enable disagrees with bus drive");

  irq_polarity_a: assert property (@(posedge clk) disable iff (reset) // see R10
    ##1 (global_irq == ($past(irq_pol) ? $past(irq_any) : !$past(irq_any))))
    else $error("global interrupt level wrong");

  mask_blocks_a: assert property (@(posedge clk) disable iff (reset) // see R11
    ((irq_enabled & ~irq_mask_reg_q) == '0) |=> (global_irq == !$past(irq_pol)))
    else $error("masked or quiet interrupts reached global output");

  bus_release_a: assert property (@(posedge clk) disable iff (reset) // see R18
    (acc_q != ohp_pkg::ACC_READ && !start_read) |=> !data_oe)
    else $error("data bus driven outside a read");

  unselected_quiet_a: assert property (@(posedge clk) disable iff (reset) // see R20
    (acc_q == ohp_pkg::ACC_IDLE && !any_sel) |=> (acc_q == ohp_pkg::ACC_IDLE))
    else $error("unselected strobe started an access");

  opt_read_cov: cover property (@(posedge clk) disable iff (reset) start_read && opt_sel);
  uart_write_cov: cover property (@(posedge clk) disable iff (reset) commit && !acc_opt_q);
  irq_fire_cov: cover property (@(posedge clk) disable iff (reset) irq_any && irq_pol);
  panel_refuse_cov: cover property (@(posedge clk) disable iff (reset)
    pins_q.multi_panel_mode && !pins_q.channel_select_n && !panel_hit);

endmodule
`default_nettype wire

/* dv/ohp_cpu_model.sv */
// ohp_cpu_model: host cpu on the eight bit parallel bus of the port
// assumes: clk is the port clock; strobes held well beyond the two-flop sync
`timescale 1ns/1ps
`default_nettype none
module ohp_cpu_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic transceiver_enable_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic channel_select_n,
  output logic option_select_n
);
  // ==========================================================
  // bus wire
  logic [7:0] drv_q = 8'h00;
  logic drv_en_q = 1'b0;
  logic [7:0] last_q = 8'h00;
  // released bus has no pull, so it shows the inverse of its last level
  always @(posedge clk) last_q <= data_in;
  assign data_in = data_oe ? data_out : (drv_en_q ? drv_q : ~last_q);

  initial begin
    addr = 8'h00;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    channel_select_n = 1'b1;
    option_select_n = 1'b1;
  end

  // ==========================================================
  // one transfer: strobe low eight clocks, then high six clocks
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
      input logic cs_n, input logic opt_n, output logic [7:0] rd, output logic oe_seen,
      output logic buf_n);
    rd = 8'h00;
    oe_seen = 1'b0;
    buf_n = 1'b1;
    @(posedge clk);
    addr <= a;
    channel_select_n <= cs_n;
    option_select_n <= opt_n;
    drv_q <= wd;
    drv_en_q <= wr;
    read_strobe_n <= wr;
    write_strobe_n <= !wr;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      if (!wr && data_oe === 1'b1 && !oe_seen) begin
        rd = data_out;
        oe_seen = 1'b1;
        buf_n = transceiver_enable_n;
      end
    end
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    // select and data outlive the strobe so the sync sees a clean end
    repeat (2) @(posedge clk);
    drv_en_q <= 1'b0;
    channel_select_n <= 1'b1;
    option_select_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* dv/octal_uart_host_bus_port_test.sv */
// octal_uart_host_bus_port_test: self-checking bench of ohp_host_port
// assumes: ohp_cpu_model drives the host pins; status inputs driven here
`timescale 1ns/1ps
`default_nettype none
module octal_uart_host_bus_port_test;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] tog;
    logic txr, rxr, busy, etx, erx;
  } ohp_row_s;
  logic clk, reset, mpm, data_oe, rs_n, ws_n, cs_n, os_n, ten_n, girq, oe, bn;
  logic [1:0] pid;
  logic [7:0] addr, data_in, data_out, ch_irq, txr, rxr, busy, tx_n, rx_n, rd;
  int bad_count = 0;
  int cmp_count = 0;
  // channel 1 pin modes; 8'hcd aliases 8'h0d while top lines are ignored
  ohp_row_s rows [7] = '{
    '{8'h0d, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1},
    '{8'hcd, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
    '{8'h0d, 8'h23, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
    '{8'h0d, 8'h83, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1},
    '{8'h0d, 8'h73, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1},
    '{8'h0d, 8'h73, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
    '{8'h0d, 8'h01, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1}};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ohp_host_port #(.NUM_CH(8)) uut (.clk(clk), .reset(reset), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .read_strobe_n(rs_n),
    .write_strobe_n(ws_n), .channel_select_n(cs_n), .option_select_n(os_n),
    .multi_panel_mode(mpm), .panel_id(pid), .transceiver_enable_n(ten_n),
    .global_irq(girq), .channel_irq(ch_irq), .tx_fifo_ready(txr), .rx_fifo_ready(rxr),
    .tx_busy(busy), .tx_ready_n(tx_n), .rx_ready_n(rx_n));
  ohp_cpu_model cpu (.clk(clk), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .transceiver_enable_n(ten_n), .read_strobe_n(rs_n),
    .write_strobe_n(ws_n), .channel_select_n(cs_n), .option_select_n(os_n));

  // ==========================================================
  // checking and bus helpers
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d, input logic c_n, o_n);
    cpu.access(1'b1, a, d, c_n, o_n, rd, oe, bn);
  endtask
  task automatic rdck(input string n, input logic [7:0] a, input logic c_n, o_n,
      input logic [7:0] exp);
    cpu.access(1'b0, a, 8'h00, c_n, o_n, rd, oe, bn);
    chk(n, rd, exp);
    chk("read oe", {7'h00, oe}, 8'h01);
    chk("oe released", {7'h00, data_oe}, 8'h00);
    chk("buf level", {7'h00, bn}, {7'h00, !mpm});
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk);
    chk("global irq", {7'h00, girq}, {7'h00, v});
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    mpm = 1'b0;
    pid = 2'h2;
    {ch_irq, txr, rxr, busy} = 32'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].tog, 1'b0, 1'b1);
      rdck("toggle", rows[i].a, 1'b0, 1'b1, rows[i].tog);
      txr <= {6'h00, rows[i].txr, 1'b0};
      rxr <= {6'h00, rows[i].rxr, 1'b0};
      busy <= {6'h00, rows[i].busy, 1'b0};
      repeat (3) @(posedge clk);
      chk("tx pin", {7'h00, tx_n[1]}, {7'h00, rows[i].etx});
      chk("rx pin", {7'h00, rx_n[1]}, {7'h00, rows[i].erx});
      $display("row %0d done", i);
    end
    // strobes without select leave registers and bus alone
    wr(8'h0d, 8'h5a, 1'b1, 1'b1);
    rdck("toggle kept", 8'h0d, 1'b0, 1'b1, 8'h01);
    cpu.access(1'b0, 8'h0d, 8'h00, 1'b1, 1'b1, rd, oe, bn);
    chk("idle oe", {7'h00, oe}, 8'h00);
    wr(8'h0d, 8'h5a, 1'b1, 1'b0); // option select ignored in normal mode
    rdck("toggle kept", 8'h0d, 1'b0, 1'b1, 8'h01);
    $display("unselected test done");
    // merge: ch2 irq enabled, polarity low then high, then channel switched off
    ch_irq <= 8'h04;
    wr(8'h14, 8'h08, 1'b0, 1'b1);
    irq_is(1'b0);
    wr(8'h06, 8'h20, 1'b0, 1'b1);
    irq_is(1'b1);
    wr(8'h16, 8'h10, 1'b0, 1'b1);
    irq_is(1'b0);
    wr(8'h16, 8'h00, 1'b0, 1'b1);
    irq_is(1'b1);
    $display("irq test done");
    // multi-panel: options, mask, panel match, buffer enable
    mpm <= 1'b1;
    repeat (3) @(posedge clk);
    rdck("poll", 8'h81, 1'b1, 1'b0, 8'h04);
    chk("buf enable", {7'h00, bn}, 8'h00);
    wr(8'h80, 8'h04, 1'b1, 1'b0);
    irq_is(1'b0);
    rdck("mask", 8'h80, 1'b1, 1'b0, 8'h04);
    wr(8'h4d, 8'h33, 1'b0, 1'b1);
    rdck("other panel", 8'h8d, 1'b0, 1'b1, 8'h01);
    wr(8'h8d, 8'h33, 1'b0, 1'b1);
    rdck("own panel", 8'h8d, 1'b0, 1'b1, 8'h33);
    $display("multi-panel test done");
    // reset in mid-run returns idle pins and cleared registers
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    chk("rst oe", {7'h00, data_oe}, 8'h00);
    chk("rst buf", {7'h00, ten_n}, 8'h01);
    chk("rst irq", {7'h00, girq}, 8'h01);
    reset <= 1'b0;
    mpm <= 1'b0;
    repeat (3) @(posedge clk);
    rdck("rst toggle", 8'h0d, 1'b0, 1'b1, 8'h00);
    $display("reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
